// *** bsr_pkg.sv ***
// Purpose: Shared constants and types for the burst SRAM clock and select block
// Assumes: mclk at 200 MHz samples every pin of the memory link
// Notes:   Counts derive from times in their own unit

package bsr_pkg;

    // ==========================================================
    // Configurations
    typedef enum logic [1:0] {
        CFG_X8  = 2'h0,
        CFG_X18 = 2'h1,
        CFG_X36 = 2'h2
    } bsr_cfg_t;

    localparam int AW_X8   = 20;
    localparam int DW_X8   = 8;
    localparam int NBE_X8  = 2;
    localparam int AW_X18  = 19;
    localparam int DW_X18  = 18;
    localparam int NBE_X18 = 2;
    localparam int AW_X36  = 18;
    localparam int DW_X36  = 36;
    localparam int NBE_X36 = 4;

    function automatic int addr_w(input bsr_cfg_t cfg);
        addr_w = (cfg == CFG_X8) ? AW_X8 : (cfg == CFG_X18) ? AW_X18 : AW_X36;
    endfunction

    function automatic int data_w(input bsr_cfg_t cfg);
        data_w = (cfg == CFG_X8) ? DW_X8 : (cfg == CFG_X18) ? DW_X18 : DW_X36;
    endfunction

    function automatic int lanes_w(input bsr_cfg_t cfg);
        lanes_w = (cfg == CFG_X8) ? NBE_X8 : (cfg == CFG_X18) ? NBE_X18 : NBE_X36;
    endfunction

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int CLK_LOSS_NS      = 200;
    localparam int CLK_LOSS_CYC     = (CLK_LOSS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOSS_CW          = 6;
    localparam logic [LOSS_CW-1:0] LOSS_MAX = LOSS_CW'(CLK_LOSS_CYC);
    localparam int DLL_RELOCK_EDGES = 1024;
    localparam int RELOCK_CW        = 10;
    localparam logic [RELOCK_CW-1:0] RELOCK_MAX = RELOCK_CW'(DLL_RELOCK_EDGES - 1);

    // Pin order inside the four-bit clock vector
    localparam int PIN_K  = 0;
    localparam int PIN_KN = 1;
    localparam int PIN_C  = 2;
    localparam int PIN_CN = 3;
    localparam int NCLK   = 4;

endpackage

// *** bsr_clk_if.sv ***
// Purpose: Carries detected clock events and clock status between block modules
// Assumes: All signals are on mclk
// Notes:   Edge flags are one-cycle pulses

`timescale 1ns/1ps

interface bsr_clk_if;
    logic k_rise;
    logic kn_rise;
    logic out_rise;
    logic outn_rise;
    logic single_clock;
    logic dll_locked;
    logic clk_lost;

    modport mon (output k_rise, kn_rise, out_rise, outn_rise, single_clock, dll_locked, clk_lost);
    modport core (input k_rise, kn_rise, out_rise, outn_rise, single_clock, dll_locked, clk_lost);
endinterface

// *** bsr_clk_mon.sv ***
// Purpose: Samples the link clocks, finds edges, detects clock loss and single-clock mode
// Assumes: Link clocks are much slower than mclk
// Notes:   DLL is modelled as a relock counter of input clock edges

`timescale 1ns/1ps

module bsr_clk_mon (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic k,
    input  wire logic k_n,
    input  wire logic c,
    input  wire logic c_n,
    bsr_clk_if.mon    cif
);
    import bsr_pkg::*;

    logic [NCLK-1:0]      s1;
    logic [NCLK-1:0]      s2;
    logic [NCLK-1:0]      s3;
    logic [NCLK-1:0]      rise;
    logic [LOSS_CW-1:0]   k_idle;
    logic [LOSS_CW-1:0]   c_high;
    logic [RELOCK_CW-1:0] lock_cnt;
    logic                 locked;
    logic [2:0]           armed;

    // ==========================================================
    // Synchronisers and edge detect
    // Edges count only once the last stage holds a real pin sample, so no false edge follows reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= '0;
        end else begin
            armed <= {armed[1:0], 1'b1};
        end
    end

    generate
        for (genvar i = 0; i < NCLK; i++) begin : g_sync
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                end else begin
                    s1[i] <= (i == PIN_K) ? k : (i == PIN_KN) ? k_n : (i == PIN_C) ? c : c_n;
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                end
            end
            assign rise[i] = s2[i] & ~s3[i] & armed[2];
        end
    endgenerate

    // ==========================================================
    // Input clock loss
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            k_idle <= '0;
        end else if (rise[PIN_K]) begin
            k_idle <= '0;
        end else if (k_idle != LOSS_MAX) begin
            k_idle <= k_idle + 1'b1;
        end
    end

    assign cif.clk_lost = (k_idle == LOSS_MAX);

    // Lost clock resets the loop; relock after a run of input edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt <= '0;
            locked   <= 1'b0;
        end else if (cif.clk_lost) begin
            lock_cnt <= '0;
            locked   <= 1'b0;
        end else if (rise[PIN_K] && !locked) begin
            lock_cnt <= lock_cnt + 1'b1;
            locked   <= (lock_cnt == RELOCK_MAX);
        end
    end

    // ==========================================================
    // Output clock pair held high selects the input pair
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            c_high <= '0;
        end else if (!(s2[PIN_C] && s2[PIN_CN])) begin
            c_high <= '0;
        end else if (c_high != LOSS_MAX) begin
            c_high <= c_high + 1'b1;
        end
    end

    assign cif.single_clock = (c_high == LOSS_MAX);
    assign cif.dll_locked   = locked;
    assign cif.k_rise       = rise[PIN_K];
    assign cif.kn_rise      = rise[PIN_KN];
    assign cif.out_rise     = cif.single_clock ? rise[PIN_K] : rise[PIN_C];
    assign cif.outn_rise    = cif.single_clock ? rise[PIN_KN] : rise[PIN_CN];

    // ==========================================================
    // Checks
    a_dll_reset: assert property (@(posedge mclk) disable iff (!arst_n)
        cif.clk_lost |=> !locked)
        else $error("loop not reset on clock loss");

    c_relock: cover property (@(posedge mclk) disable iff (!arst_n) $rose(locked));

endmodule

// *** bsr_top.sv ***
// Purpose: Clock, echo clock and port select logic of a two-word burst SRAM
// Assumes: Memory core answers a read request with both words one mclk later
// Notes:   Link pins are sampled by mclk; all outputs are on mclk
//
// Function
// - Lost input clock resets the delay loop, which relocks when clock returns.
// - Output clock pair held high makes reads time from the input pair.
// - Echo clocks are complementary, both edges aligned with read data.
// - Active output clock rise drives true echo high, complement low.
// - Complement echo rising marks the first word of each read.
// - Port selects are sampled only on true input clock rising edges.
// - Read port selection never affects writes, and the reverse.
// - Deselecting a port still completes every accepted burst.
// - Eight-bit configuration: 20 address bits, 8 data bits, two nibble enables.
// - Eighteen-bit configuration: 19 address bits, 18 data bits, two byte enables.
// - Thirty-six-bit configuration: 18 address bits, 36 data bits, byte enables.
// - Upper nibble enable gates bits 4-7, lower nibble gates bits 0-3.
// - Eighteen-bit upper byte enable gates bits 9 through 17.
// - Eighteen-bit lower byte enable gates bits 0 through 8.
// - Read selected at input clock rise returns two words after next complement rise.
// - Write: select at clock rise, address at complement rise, data both edges.
// - First read word launches on complement output rise, second on true rise.

`timescale 1ns/1ps

module bsr_top #(
    parameter  bsr_pkg::bsr_cfg_t CFG = bsr_pkg::CFG_X18,
    localparam int                AW  = bsr_pkg::addr_w(CFG),
    localparam int                DW  = bsr_pkg::data_w(CFG),
    localparam int                NBE = bsr_pkg::lanes_w(CFG)
) (
    input  wire logic            mclk,
    input  wire logic            arst_n,
    input  wire logic            k,
    input  wire logic            k_n,
    input  wire logic            c,
    input  wire logic            c_n,
    input  wire logic            read_select_n,
    input  wire logic            write_select_n,
    input  wire logic [AW-1:0]   addr,
    input  wire logic [DW-1:0]   wdata,
    input  wire logic [NBE-1:0]  write_lane_enable_n,
    output logic      [DW-1:0]   q,
    output logic                 q_oe,
    output logic                 echo_timing_out_p,
    output logic                 echo_timing_out_n,
    output logic                 dll_locked,
    output logic                 single_clock_mode,
    output logic                 rd_req,
    output logic      [AW-1:0]   rd_addr,
    input  wire logic [2*DW-1:0] rd_data,
    output logic                 wr_req,
    output logic      [AW-1:0]   wr_addr,
    output logic      [2*DW-1:0] wr_data,
    output logic      [2*DW-1:0] wr_mask
);
    import bsr_pkg::*;

    localparam int LW = DW / NBE;
    localparam int SW = 2 + AW + DW + NBE;

    bsr_clk_if cif ();

    logic [SW-1:0]     p1;
    logic [SW-1:0]     p2;
    logic              rsel_s;
    logic              wsel_s;
    logic [AW-1:0]     addr_s;
    logic [DW-1:0]     wdata_s;
    logic [NBE-1:0]    be_s;
    logic [DW-1:0]     lane_mask;
    logic              rd_take;
    logic              rd_pend;
    logic [2*DW-1:0]   rd_buf;
    logic              w1_valid;
    logic [DW-1:0]     word1;
    logic              w_active;
    logic [DW-1:0]     wbuf0;
    logic [DW-1:0]     wmask0;

    // ==========================================================
    // Clock monitor
    bsr_clk_mon u_clk_mon (
        .mclk   (mclk),
        .arst_n (arst_n),
        .k      (k),
        .k_n    (k_n),
        .c      (c),
        .c_n    (c_n),
        .cif    (cif)
    );

    assign dll_locked        = cif.dll_locked;
    assign single_clock_mode = cif.single_clock;

    // ==========================================================
    // Pin synchronisers, aligned with the clock edge detect
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            p1 <= '1;
            p2 <= '1;
        end else begin
            p1 <= {read_select_n, write_select_n, addr, wdata, write_lane_enable_n};
            p2 <= p1;
        end
    end

    assign {rsel_s, wsel_s, addr_s, wdata_s, be_s} = p2;

    // Widths follow the selected configuration
    generate
        for (genvar i = 0; i < DW; i++) begin : g_lane
            assign lane_mask[i] = ~be_s[i / LW];
        end
    endgenerate

    // ==========================================================
    // Read accept: select seen only at true input clock rise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_req  <= 1'b0;
            rd_addr <= '0;
        end else begin
            rd_req <= cif.k_rise & ~rsel_s;
            if (cif.k_rise && !rsel_s) begin
                rd_addr <= addr_s;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_take <= 1'b0;
            rd_buf  <= '0;
        end else begin
            rd_take <= rd_req;
            if (rd_take) begin
                rd_buf <= rd_data;
            end
        end
    end

    // Accepted read waits for the next complement output rise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_pend <= 1'b0;
        end else if (cif.k_rise && !rsel_s) begin
            rd_pend <= 1'b1;
        end else if (cif.outn_rise) begin
            rd_pend <= 1'b0;
        end
    end

    // ==========================================================
    // Read launch; a later deselect never cuts a burst short
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q        <= '0;
            q_oe     <= 1'b0;
            word1    <= '0;
            w1_valid <= 1'b0;
        end else if (cif.outn_rise) begin
            q_oe     <= rd_pend;
            w1_valid <= rd_pend;
            if (rd_pend) begin
                q     <= rd_buf[DW-1:0];
                word1 <= rd_buf[2*DW-1:DW];
            end
        end else if (cif.out_rise) begin
            q_oe     <= w1_valid;
            w1_valid <= 1'b0;
            if (w1_valid) begin
                q <= word1;
            end
        end
    end

    // Echo pair: true rises with output clock, complement with its partner
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            echo_timing_out_p <= 1'b0;
            echo_timing_out_n <= 1'b1;
        end else if (cif.out_rise) begin
            echo_timing_out_p <= 1'b1;
            echo_timing_out_n <= 1'b0;
        end else if (cif.outn_rise) begin
            echo_timing_out_p <= 1'b0;
            echo_timing_out_n <= 1'b1;
        end
    end

    // ==========================================================
    // Write: first word with select, address and second word at complement rise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            w_active <= 1'b0;
            wbuf0    <= '0;
            wmask0   <= '0;
        end else if (cif.k_rise) begin
            w_active <= ~wsel_s;
            if (!wsel_s) begin
                wbuf0  <= wdata_s;
                wmask0 <= lane_mask;
            end
        end else if (cif.kn_rise) begin
            w_active <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_req  <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_mask <= '0;
        end else begin
            wr_req <= cif.kn_rise & w_active;
            if (cif.kn_rise && w_active) begin
                wr_addr <= addr_s;
                wr_data <= {wdata_s, wbuf0};
                wr_mask <= {lane_mask, wmask0};
            end
        end
    end

    // ==========================================================
    // Checks
    a_echo_compl: assert property (@(posedge mclk) disable iff (!arst_n)
        echo_timing_out_p != echo_timing_out_n)
        else $error("echo pair not complementary");

    a_echo_rise: assert property (@(posedge mclk) disable iff (!arst_n)
        cif.out_rise |=> echo_timing_out_p && !echo_timing_out_n)
        else $error("echo did not follow output clock rise");

    a_first_word: assert property (@(posedge mclk) disable iff (!arst_n)
        (cif.outn_rise && rd_pend) |=> q_oe && $rose(echo_timing_out_n) && q == $past(rd_buf[DW-1:0]))
        else $error("first read word not marked by complement echo");

    a_second_word: assert property (@(posedge mclk) disable iff (!arst_n)
        (cif.out_rise && w1_valid) |=> q_oe && q == $past(word1) && echo_timing_out_p)
        else $error("second read word lost");

    a_sel_k_only: assert property (@(posedge mclk) disable iff (!arst_n)
        rd_req |-> $past(cif.k_rise) && !$past(rsel_s))
        else $error("read accepted off input clock rise");

    a_rd_wr_indep: assert property (@(posedge mclk) disable iff (!arst_n)
        (cif.k_rise && !rsel_s && !wsel_s) |=> rd_req ##0 w_active)
        else $error("ports interfere");

    a_wr_pair: assert property (@(posedge mclk) disable iff (!arst_n)
        (cif.kn_rise && w_active) |=> wr_req && wr_addr == $past(addr_s) && wr_data[DW-1:0] == $past(wbuf0))
        else $error("write not completed at complement rise");

    a_lane_map: assert property (@(posedge mclk) disable iff (!arst_n)
        lane_mask[0] == !be_s[0] && lane_mask[LW] == !be_s[1] && lane_mask[DW-1] == !be_s[NBE-1])
        else $error("lane enable mapping wrong");

    a_single_src: assert property (@(posedge mclk) disable iff (!arst_n)
        cif.single_clock |-> (cif.out_rise == cif.k_rise) && (cif.outn_rise == cif.kn_rise))
        else $error("single clock mode not using input pair");

    a_read_lat: assert property (@(posedge mclk) disable iff (!arst_n)
        rd_req |-> rd_pend)
        else $error("accepted read not pending");

    c_read: cover property (@(posedge mclk) disable iff (!arst_n) cif.outn_rise && rd_pend);
    c_write: cover property (@(posedge mclk) disable iff (!arst_n) wr_req);
    c_single: cover property (@(posedge mclk) disable iff (!arst_n) cif.single_clock && q_oe);
    c_b2b_read: cover property (@(posedge mclk) disable iff (!arst_n) (rd_req ##[1:20] rd_req));

endmodule

// *** bsr_ctrl_model.sv ***
// Purpose: Controller side of the memory link: input clock pair and output clock pair
// Assumes: Half period of 24 ns; output pair trails the input pair by a fixed delay
// Notes:   run low stops the input clock; single high ties both output clocks high

`timescale 1ns/1ps

module bsr_ctrl_model #(
    parameter real HALF  = 24.0,
    parameter real C_DLY = 2.0
) (
    output logic      k,
    output logic      k_n,
    output logic      c,
    output logic      c_n,
    input  wire logic run,
    input  wire logic single
);
    logic k_dly;

    // ==========================================================
    // Input clock pair, stopped in place while run is low
    initial begin
        k = 1'b0;
        k_dly = 1'b0;
        forever begin
            #(HALF);
            if (run) begin
                k = ~k;
            end
        end
    end
    assign k_n = ~k;

    // ==========================================================
    // Output clock pair: delayed copy, or both held high
    always @(k) begin
        k_dly <= #(C_DLY) k;
    end
    assign c   = single ? 1'b1 : k_dly;
    assign c_n = single ? 1'b1 : ~k_dly;
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the burst SRAM clock and select block
// Assumes: Eighteen-bit configuration; link clocks from bsr_ctrl_model
// Notes:   Pins change mid half period so the synchronisers see stable values

`timescale 1ns/1ps

module tb_top;
    import bsr_pkg::*;
    localparam int AW = AW_X18;
    localparam int DW = DW_X18;

    logic                mclk, arst_n, k, k_n, c, c_n, run, single;
    logic                rsel_n, wsel_n, q_oe, echo_p, echo_n, dll_locked;
    logic                single_mode, rd_req, wr_req, prev_p, prev_n, rd_ans;
    logic [AW-1:0]       addr, rd_addr, wr_addr;
    logic [DW-1:0]       wdata, q;
    logic [1:0]          lanes;
    logic [2*DW-1:0]     rd_data, wr_data, wr_mask;
    logic [DW-1:0]       got[$];
    logic [DW-1:0]       exp_rd[$];
    logic [AW+4*DW-1:0]  exp_wr[$];
    int                  mismatches, cmp_count, rd_cnt;

    bsr_ctrl_model u_ctrl (.k(k), .k_n(k_n), .c(c), .c_n(c_n), .run(run), .single(single));

    bsr_top #(.CFG(CFG_X18)) DUT (
        .mclk(mclk), .arst_n(arst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
        .read_select_n(rsel_n), .write_select_n(wsel_n), .addr(addr), .wdata(wdata),
        .write_lane_enable_n(lanes), .q(q), .q_oe(q_oe), .echo_timing_out_p(echo_p),
        .echo_timing_out_n(echo_n), .dll_locked(dll_locked), .single_clock_mode(single_mode),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask(wr_mask)
    );

    // ==========================================================
    // Helpers
    function automatic logic [2*DW-1:0] pat(input logic [AW-1:0] a);
        pat = {DW'(a) ^ 18'h2A5A5, DW'(a) ^ 18'h15A5A};
    endfunction

    function automatic logic [DW-1:0] mk_mask(input logic [1:0] n);
        mk_mask = {{9{~n[1]}}, {9{~n[0]}}};
    endfunction

    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, core model and monitor
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Core answers one cycle after rd_req; otherwise the bus churns
    always @(negedge mclk) begin
        rd_ans  <= (rd_req === 1'b1);
        rd_data <= (rd_ans === 1'b1) ? pat(rd_addr) : ~rd_data;
    end

    // Outputs are judged at the falling edge, where they are settled
    always @(negedge mclk) begin
        if (arst_n === 1'b1) begin
            chk((echo_p ^ echo_n) === 1'b1, "echo pair");
            // Capture on each echo rise, first word on the complement
            if (q_oe === 1'b1 && echo_n === 1'b1 && prev_n === 1'b0) begin
                got.push_back(q);
            end
            if (q_oe === 1'b1 && echo_p === 1'b1 && prev_p === 1'b0) begin
                got.push_back(q);
            end
            if (rd_req === 1'b1) begin
                rd_cnt++;
            end
            if (wr_req === 1'b1) begin
                chk(exp_wr.size() > 0 && {wr_addr, wr_data, wr_mask} === exp_wr[0], "write");
                if (exp_wr.size() > 0) begin
                    void'(exp_wr.pop_front());
                end
            end
        end
        prev_p <= echo_p;
        prev_n <= echo_n;
    end

    // ==========================================================
    // One input clock period; late moves the selects to the k_n half
    task automatic kcyc(input logic rs_n, input logic ws_n, input logic late, input logic [AW-1:0] ra,
                        input logic [AW-1:0] wa, input logic [DW-1:0] w0, input logic [DW-1:0] w1,
                        input logic [1:0] m0, input logic [1:0] m1);
        logic [2*DW-1:0] p;
        p = pat(ra);
        @(posedge k_n);
        @(posedge mclk);
        repeat (2) @(negedge mclk);
        chk(echo_p === 1'b1, "echo after rise");
        rsel_n = late | rs_n;
        wsel_n = late | ws_n;
        addr = ra;
        wdata = w0;
        lanes = m0;
        @(posedge k);
        @(posedge mclk);
        repeat (2) @(negedge mclk);
        chk(echo_p === 1'b0, "echo after fall");
        rsel_n = !late | rs_n;
        wsel_n = !late | ws_n;
        addr = wa;
        wdata = w1;
        lanes = m1;
        if (!late && !rs_n) begin
            exp_rd.push_back(p[DW-1:0]);
            exp_rd.push_back(p[2*DW-1:DW]);
        end
        if (!late && !ws_n) begin
            exp_wr.push_back({wa, w1, w0, mk_mask(m1), mk_mask(m0)});
        end
    endtask

    task automatic drain_chk(input string m);
        repeat (40) @(negedge mclk);
        chk(got.size() == exp_rd.size() && exp_wr.size() == 0, m);
        while (got.size() > 0 && exp_rd.size() > 0) begin
            chk(got.pop_front() === exp_rd.pop_front(), m);
        end
        got.delete();
        exp_rd.delete();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_lock;
        chk(dll_locked === 1'b0 && q_oe === 1'b0 && echo_n === 1'b1, "reset state");
        repeat (1100) @(posedge k);
        chk(dll_locked === 1'b1, "lock");
        $display("test lock done");
    endtask

    task automatic t_rw;
        kcyc(0, 0, 0, 19'h00011, 19'h00022, 18'h0ABCD, 18'h31234, 2'h0, 2'h0);
        kcyc(0, 1, 0, 19'h7FFFF, 19'h00000, 18'h00000, 18'h00000, 2'h3, 2'h3);
        for (int i = 0; i < 4; i++) begin
            kcyc(1, 0, 0, 19'h0, 19'(i + 5), 18'h3FFFF, 18'h2AAAA ^ 18'(i), 2'(i), 2'(3 - i));
        end
        kcyc(1, 1, 0, 19'h0, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        drain_chk("read write");
        $display("test read write done");
    endtask

    task automatic t_late;
        int n;
        n = rd_cnt;
        kcyc(0, 0, 1, 19'h00333, 19'h00444, 18'h12345, 18'h2BCDE, 2'h0, 2'h0);
        // Release the late selects after the complement rise, before the next true rise
        @(posedge k_n);
        @(posedge mclk);
        repeat (2) @(negedge mclk);
        rsel_n = 1'b1;
        wsel_n = 1'b1;
        drain_chk("late select");
        chk(rd_cnt == n, "late read");
        $display("test late select done");
    endtask

    task automatic t_loss;
        @(negedge mclk) run = 1'b0;
        repeat (60) @(negedge mclk);
        chk(dll_locked === 1'b0, "loop reset");
        run = 1'b1;
        repeat (1030) @(posedge k);
        chk(dll_locked === 1'b1, "relock");
        $display("test clock loss done");
    endtask

    task automatic t_single;
        @(negedge mclk) single = 1'b1;
        repeat (60) @(negedge mclk);
        chk(single_mode === 1'b1, "single mode");
        kcyc(0, 1, 0, 19'h12345, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        kcyc(1, 1, 0, 19'h0, 19'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        drain_chk("single read");
        $display("test single clock done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        arst_n = 1'b0;
        run = 1'b1;
        single = 1'b0;
        rsel_n = 1'b1;
        wsel_n = 1'b1;
        addr = '0;
        wdata = '0;
        lanes = 2'h3;
        rd_data = '0;
        mismatches = 0;
        cmp_count = 0;
        rd_cnt = 0;
        repeat (8) @(posedge mclk);
        @(negedge mclk) arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_lock;
        t_rw;
        t_late;
        t_loss;
        t_single;
        close_out;
    end

    initial begin
        #200000;
        mismatches++;
        $display("BAD %0t watchdog", $time);
        close_out;
    end
endmodule
